// ==== src/amx_pkg.sv ====
// Package for the analog monitor request decode and multiplexer select block.
// Assumes a single 20 MHz clock domain; all constants used by the design live here.
package amx_pkg;
   // ==========================================================
   // Widths
   localparam int RA_W = 8;
   localparam int DATA_W = 16;
   localparam int ADC_W = 12;
   localparam int CHAN_W = 3;
   // ==========================================================
   // Field positions of the relative address for the on-board mux
   localparam int RA_LO_POS = 0;
   localparam int RA_HI_POS = 3;
   // ==========================================================
   // Timing
   localparam int CLK_HZ = 20_000_000;
   localparam int ENB_TIMEOUT_US = 5;
   // Scale by cycles per microsecond first: the plain product overflows a 32-bit int for the 200 us and 240 us times
   localparam int ENB_TIMEOUT_CYC = ENB_TIMEOUT_US * (CLK_HZ / 1_000_000);
   localparam int IDLE_LEAD_US = 200;
   localparam int IDLE_LEAD_CYC = IDLE_LEAD_US * (CLK_HZ / 1_000_000);
   localparam int CONV_WAIT_US = 240;
   localparam int CONV_WAIT_CYC = CONV_WAIT_US * (CLK_HZ / 1_000_000);
   // Wide enough for the digital no-response limit of twice the conversion wait
   localparam int CNT_W = 14;
   // ==========================================================
   // Reset values
   localparam logic [RA_W-1:0] RA_RST = 8'h00;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
   localparam logic [7:0] NORESP_RST = 8'h00;
   // ==========================================================
   // Request sequencer states
   typedef enum logic [2:0] {
      AMX_IDLE = 3'b000,
      AMX_LEAD = 3'b001,
      AMX_WAIT = 3'b010,
      AMX_ANLG = 3'b011,
      AMX_DIGI = 3'b100,
      AMX_DONE = 3'b101
   } amx_state_t;
endpackage

// ==== src/amx_result_reg.sv ====
// Result holding register for the monitor answer word.
// Assumes the caller presents a full word and a one-cycle load strobe.
`timescale 1ns/1ns
module amx_result_reg
   import amx_pkg::*;
#(
   parameter int WIDTH = DATA_W
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic load_i,
   input wire logic [WIDTH-1:0] word_i,
   output logic [WIDTH-1:0] word_o
);
   logic [WIDTH-1:0] word_q;
   logic [WIDTH-1:0] word_d;
   // ==========================================================
   // Next value: take the word only on a load strobe
   always_comb begin
      word_d = word_q;
      if (load_i) begin
         word_d = word_i;
      end
   end
   // Register, frozen while the clock enable is low
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         word_q <= '0;
      end else if (ce_i) begin
         word_q <= word_d;
      end
   end
   assign word_o = word_q;
endmodule // amx_result_reg

// ==== src/amx_mux_select.sv ====
// Analog monitor request sequencer and on-board mux channel select.
// Assumes the controlled device generates analog enable and the bit-group
// select combinationally from the relative address, and all inputs are synchronous.
// Behaviour
// - Between messages the address holds, data lines float, read/write, request low, ack low.
// - Idle handshake values may end up to 200 us before the request rises.
// - Monitor requests to the analog range mux, sample and convert one of 8 inputs.
// - Converted samples are two's complement at 5 mV per step in the top 12 of 16 bits.
// - Channel is address bits 0..2 when the group select is low and bits 3..5 when high.
// - Low address bits pick the channel in an external mux, high bits pick the mux.
// - Results are handled the same whether from the converter or the data lines.
`timescale 1ns/1ns
module amx_mux_select
   import amx_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic start_i,
   input wire logic read_i,
   input wire logic [RA_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic analog_enable_i,
   input wire logic mux_bit_group_select_i,
   input wire logic device_acknowledge_i,
   input wire logic [DATA_W-1:0] control_monitor_lines_i,
   input wire logic [ADC_W-1:0] adc_sample_i,
   output logic [RA_W-1:0] relative_address_o,
   output logic read_write_o,
   output logic device_request_o,
   output logic [DATA_W-1:0] control_monitor_lines_o,
   output logic control_monitor_lines_oe_o,
   output logic [CHAN_W-1:0] mux_channel_o,
   output logic adc_convert_o,
   output logic busy_o,
   output logic done_o,
   output logic no_response_o,
   output logic [DATA_W-1:0] result_o,
   output logic [7:0] no_response_count_o
);
   // ==========================================================
   // Shared helpers
   function automatic logic [CHAN_W-1:0] pick_chan(input logic [RA_W-1:0] ra, input logic hi);
      pick_chan = hi ? ra[RA_HI_POS +: CHAN_W] : ra[RA_LO_POS +: CHAN_W];
   endfunction
   amx_state_t state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [RA_W-1:0] ra_q, ra_d;
   logic rw_q, rw_d;
   logic req_q, req_d;
   logic [DATA_W-1:0] cmo_q, cmo_d;
   logic oe_q, oe_d;
   logic [CHAN_W-1:0] chan_q, chan_d;
   logic conv_q, conv_d;
   logic done_q, done_d;
   logic nresp_q, nresp_d;
   logic [7:0] ncnt_q, ncnt_d;
   logic load;
   logic [DATA_W-1:0] word;
   logic anlg_seen;
   logic busy_q, busy_d;
   // ==========================================================
   // Enable only counts while the request is up
   assign anlg_seen = req_q & rw_q & analog_enable_i;
   // Sequencer next state
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      ra_d = ra_q;
      rw_d = rw_q;
      req_d = req_q;
      cmo_d = cmo_q;
      oe_d = oe_q;
      chan_d = chan_q;
      conv_d = 1'b0;
      done_d = 1'b0;
      nresp_d = 1'b0;
      ncnt_d = ncnt_q;
      load = 1'b0;
      word = DATA_RST;
      unique case (state_q)
         AMX_IDLE: begin
            rw_d = 1'b0;
            req_d = 1'b0;
            oe_d = 1'b0;
            if (start_i) begin
               ra_d = addr_i; // Address holds until the next message
               rw_d = read_i;
               cmo_d = wdata_i;
               oe_d = !read_i;
               cnt_d = '0;
               state_d = AMX_LEAD;
            end
         end
         AMX_LEAD: begin
            // Lead time: idle values end before the request rises
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == CNT_W'(IDLE_LEAD_CYC - 1)) begin
               req_d = 1'b1;
               cnt_d = '0;
               state_d = AMX_WAIT;
            end
         end
         AMX_WAIT: begin
            cnt_d = cnt_q + 1'b1;
            chan_d = pick_chan(ra_q, mux_bit_group_select_i);
            if (anlg_seen) begin
               cnt_d = '0;
               state_d = AMX_ANLG;
            end else if (device_acknowledge_i) begin
               if (rw_q) begin
                  load = 1'b1;
                  word = control_monitor_lines_i;
               end
               state_d = AMX_DONE;
            // Writes leave through the same timeout, so a silent device cannot hang us
            end else if (cnt_q == CNT_W'(ENB_TIMEOUT_CYC - 1)) begin
               state_d = AMX_DIGI; // No enable: treat as digital request
            end
         end
         AMX_DIGI: begin
            // Digital monitor wait; timeout counted as no response
            cnt_d = cnt_q + 1'b1;
            if (device_acknowledge_i) begin
               // A late write ack only closes the message; nothing to load
               if (rw_q) begin
                  load = 1'b1;
                  word = control_monitor_lines_i;
               end
               state_d = AMX_DONE;
            end else if (cnt_q == CNT_W'(CONV_WAIT_CYC * 2)) begin
               nresp_d = 1'b1;
               ncnt_d = ncnt_q + 8'h01;
               state_d = AMX_DONE;
            end
         end
         AMX_ANLG: begin
            // Mux follows the far side's select while settling
            chan_d = pick_chan(ra_q, mux_bit_group_select_i);
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == CNT_W'(CONV_WAIT_CYC - 1)) begin
               conv_d = 1'b1;
               load = 1'b1;
               word = {adc_sample_i, 4'h0}; // Top 12 bits, two's complement
               state_d = AMX_DONE;
            end
         end
         AMX_DONE: begin
            req_d = 1'b0;
            oe_d = 1'b0;
            rw_d = 1'b0;
            done_d = 1'b1;
            state_d = AMX_IDLE;
         end
         default: begin
            state_d = AMX_IDLE;
         end
      endcase
      // Busy flag registered so the port comes straight from a flop
      busy_d = (state_d != AMX_IDLE);
   end
   // Sequencer registers
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= AMX_IDLE;
         cnt_q <= '0;
         ra_q <= RA_RST;
         rw_q <= 1'b0;
         req_q <= 1'b0;
         cmo_q <= DATA_RST;
         oe_q <= 1'b0;
         chan_q <= '0;
         conv_q <= 1'b0;
         done_q <= 1'b0;
         nresp_q <= 1'b0;
         ncnt_q <= NORESP_RST;
         busy_q <= 1'b0;
      end else if (ce_i) begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         ra_q <= ra_d;
         rw_q <= rw_d;
         req_q <= req_d;
         cmo_q <= cmo_d;
         oe_q <= oe_d;
         chan_q <= chan_d;
         conv_q <= conv_d;
         done_q <= done_d;
         nresp_q <= nresp_d;
         ncnt_q <= ncnt_d;
         busy_q <= busy_d;
      end
   end
   // Result word kept in its own register, one path for both sources
   amx_result_reg #(
      .WIDTH(DATA_W)
   ) u_result (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .load_i(load),
      .word_i(word),
      .word_o(result_o)
   );
   assign relative_address_o = ra_q;
   assign read_write_o = rw_q;
   assign device_request_o = req_q;
   assign control_monitor_lines_o = cmo_q;
   assign control_monitor_lines_oe_o = oe_q;
   assign mux_channel_o = chan_q;
   assign adc_convert_o = conv_q;
   assign busy_o = busy_q;
   assign done_o = done_q;
   assign no_response_o = nresp_q;
   assign no_response_count_o = ncnt_q;
endmodule // amx_mux_select

// ==== dv/amx_sva.sv ====
// Port assertions for the analog monitor select block.
// Assumes a bind onto amx_mux_select, one clock domain.
`timescale 1ns/1ns
module amx_sva
   import amx_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic mux_bit_group_select_i,
   input wire logic device_acknowledge_i,
   input wire logic [RA_W-1:0] relative_address_o,
   input wire logic read_write_o,
   input wire logic device_request_o,
   input wire logic control_monitor_lines_oe_o,
   input wire logic [CHAN_W-1:0] mux_channel_o,
   input wire logic adc_convert_o,
   input wire logic busy_o,
   input wire logic done_o,
   input wire logic no_response_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   logic [CNT_W-1:0] lead_q;
   logic [CNT_W-1:0] lead_d;
   // ==========================================
   // Lead counter, cleared once the request is up
   always_comb begin
      lead_d = (busy_o && !device_request_o) ? lead_q + 1'b1 : '0;
   end
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lead_q <= '0;
      end else begin
         lead_q <= lead_d;
      end
   end
   // Idle lines only; a late read would let a stale channel through
   AST_IDLE_LINES: assert property (!busy_o |-> !read_write_o && !control_monitor_lines_oe_o)
      else $error("handshake lines not idle");
   AST_ADDR_HOLD: assert property (!busy_o |-> $stable(relative_address_o))
      else $error("address moved between messages");
   AST_OE_WRITE: assert property (control_monitor_lines_oe_o |-> !read_write_o)
      else $error("data lines driven on a read");
   AST_REQ_BUSY: assert property (device_request_o |-> busy_o)
      else $error("request outside a message");
   AST_REQ_LEAD: assert property ($rose(device_request_o) |-> lead_q <= IDLE_LEAD_CYC)
      else $error("request lead too long");
   AST_CONV_READ: assert property (adc_convert_o |-> read_write_o)
      else $error("conversion without a read");
   AST_MUX_CHAN: assert property (device_request_o && read_write_o
      && $past(device_request_o, 2) |-> mux_channel_o == ($past(mux_bit_group_select_i)
      ? relative_address_o[5:3] : relative_address_o[2:0]))
      else $error("wrong mux channel");
   AST_ACK_DONE: assert property (device_request_o && device_acknowledge_i
      |-> ##[1:2] !device_request_o)
      else $error("ack not answered");
   // A conversion or a no-response must close the message on the next cycle
   AST_CONV_DONE: assert property (adc_convert_o |=> done_o && !device_request_o)
      else $error("conversion not closed by done");
   AST_NRESP_DONE: assert property (no_response_o |=> done_o && !device_request_o)
      else $error("no-response not closed by done");
endmodule // amx_sva

// ==== dv/amx_dev_model.sv ====
// Device glue model: one external mux on input 1, digital ack after 50 cycles.
// Assumes the select block drives request, read and address.
`timescale 1ns/1ns
module amx_dev_model
   import amx_pkg::*;
(
   input wire logic mclk_i,
   input wire logic req_i,
   input wire logic rd_i,
   input wire logic [RA_W-1:0] addr_i,
   input wire logic silent_i,
   input wire logic anlg_off_i,
   output logic analog_enable_o,
   output logic sel_o,
   output logic ack_o,
   output logic [DATA_W-1:0] data_o,
   output logic [ADC_W-1:0] adc_o
);
   logic [7:0] wait_q = 8'h00;
   logic [DATA_W-1:0] junk_q = 16'h5a5a;
   logic anlg;
   // ==========================================
   // Decode is purely combinational, so select follows address at once
   assign anlg = !anlg_off_i && addr_i <= 8'h0f;
   assign analog_enable_o = rd_i && req_i && anlg && !silent_i;
   assign sel_o = anlg && addr_i >= 8'h08;
   assign ack_o = req_i && !(rd_i && anlg) && !silent_i && wait_q == 8'h32;
   assign data_o = (ack_o && rd_i) ? {8'ha5, addr_i} : junk_q;
   assign adc_o = {4'h8, addr_i};
   // Released data lines toggle so stale values cannot pass
   always_ff @(posedge mclk_i) begin
      junk_q <= ~junk_q;
      wait_q <= !req_i ? 8'h00 : (wait_q == 8'h32 ? wait_q : wait_q + 8'h01);
   end
endmodule // amx_dev_model

// ==== dv/tb_top.sv ====
// Self-checking bench for amx_mux_select with the device model.
// Assumes the checker and model files are compiled first.
`timescale 1ns/1ns
module tb_top
   import amx_pkg::*;
;
   logic mclk_i = 1'b0, rst_b_i = 1'b0, ce_i = 1'b1, start_i = 1'b0, read_i = 1'b0;
   logic silent = 1'b0, anoff = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [15:0] wdata_i = 16'h0000;
   logic analog_enable_i, mux_bit_group_select_i, device_acknowledge_i;
   logic [15:0] control_monitor_lines_i, control_monitor_lines_o, result_o;
   logic [11:0] adc_sample_i;
   logic [7:0] relative_address_o, no_response_count_o;
   logic [2:0] mux_channel_o;
   logic read_write_o, device_request_o, control_monitor_lines_oe_o, adc_convert_o;
   logic busy_o, done_o, no_response_o;
   int fail_count = 0, num_checks = 0, cyc = 0;
   // ==========================================
   // Design, device model, clock and hang guard
   amx_mux_select i_dut (.mclk_i, .rst_b_i, .ce_i, .start_i, .read_i, .addr_i, .wdata_i,
      .analog_enable_i, .mux_bit_group_select_i, .device_acknowledge_i,
      .control_monitor_lines_i, .adc_sample_i, .relative_address_o, .read_write_o,
      .device_request_o, .control_monitor_lines_o, .control_monitor_lines_oe_o, .mux_channel_o,
      .adc_convert_o, .busy_o, .done_o, .no_response_o, .result_o, .no_response_count_o);
   amx_dev_model i_dev (.mclk_i(mclk_i), .req_i(device_request_o), .rd_i(read_write_o),
      .addr_i(relative_address_o), .silent_i(silent), .anlg_off_i(anoff),
      .analog_enable_o(analog_enable_i), .sel_o(mux_bit_group_select_i),
      .ack_o(device_acknowledge_i), .data_o(control_monitor_lines_i), .adc_o(adc_sample_i));
   initial forever #25 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         stop_test();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      if (fail_count == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // One message; a stray start mid-way must be ignored
   task automatic msg(input logic r, input logic [7:0] a, input logic [15:0] exp, input logic e_nr,
      input logic [2:0] e_ch, input logic e_cv);
      logic nr_seen;
      logic cv_seen;
      nr_seen = 1'b0;
      cv_seen = 1'b0;
      read_i = r;
      addr_i = a;
      wdata_i = {a, 8'h3c};
      start_i = 1'b1;
      // Bound covers the digital no-response path, the longest message
      for (int n = 0; n < 20000 && !done_o; n++) begin
         @(posedge mclk_i);
         #5;
         start_i = (n == 200);
         nr_seen |= no_response_o;
         cv_seen |= adc_convert_o;
         if (n == 10) chk(16'(busy_o), 16'h0001);
         if (n == IDLE_LEAD_CYC - 1) chk(16'(device_request_o), 16'h0000);
         if (n == IDLE_LEAD_CYC) chk(16'(device_request_o), 16'h0001);
         if (n == IDLE_LEAD_CYC + 10 && !r) chk(control_monitor_lines_o, {a, 8'h3c});
         if (n == IDLE_LEAD_CYC + 10 && !r) chk(16'(control_monitor_lines_oe_o), 16'h0001);
      end
      chk(16'(done_o), 16'h0001);
      chk(16'(relative_address_o), 16'(a));
      chk(16'(mux_channel_o), 16'(e_ch));
      chk(16'(cv_seen), 16'(e_cv));
      chk(16'(nr_seen), 16'(e_nr));
      if (r && !e_nr) chk(result_o, exp);
      @(posedge mclk_i);
      #5;
      chk(16'({busy_o, read_write_o}), 16'h0000);
      chk(16'({device_request_o, control_monitor_lines_oe_o}), 16'h0000);
   endtask
   initial begin
      repeat (12) @(posedge mclk_i);
      #5 rst_b_i = 1'b1;
      msg(1'b1, 8'h03, {4'h8, 8'h03, 4'h0}, 1'b0, 3'h3, 1'b1);
      msg(1'b1, 8'h0d, {4'h8, 8'h0d, 4'h0}, 1'b0, 3'h1, 1'b1);
      msg(1'b1, 8'h40, {8'ha5, 8'h40}, 1'b0, 3'h0, 1'b0);
      msg(1'b0, 8'h05, 16'h0000, 1'b0, 3'h5, 1'b0);
      silent = 1'b1;
      msg(1'b1, 8'h02, 16'h0000, 1'b1, 3'h2, 1'b0);
      silent = 1'b0;
      chk(16'(no_response_count_o), 16'h0001);
      anoff = 1'b1;
      msg(1'b1, 8'h02, {8'ha5, 8'h02}, 1'b0, 3'h2, 1'b0);
      chk(16'(no_response_count_o), 16'h0001);
      stop_test();
   end
endmodule // tb_top
bind amx_mux_select amx_sva i_sva (.mclk_i, .rst_b_i, .mux_bit_group_select_i,
   .device_acknowledge_i, .relative_address_o, .read_write_o, .device_request_o,
   .control_monitor_lines_oe_o, .mux_channel_o, .adc_convert_o, .busy_o, .done_o, .no_response_o);
